// [testbench/nirc_cpu_model.sv]
// Purpose: cpu side partner that takes pending nmi requests
// Assumes: nmi_request is a registered level
// Notes: one accept pulse per request, on the DELAY+1th clock that samples it high
`timescale 1ns/1ps
module nirc_cpu_model
  import nirc_pkg::*;
#(
  parameter int DELAY = 2
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // nmi handshake
  input wire logic nmi_request,
  output logic nmi_accept
);
  int cnt;
  logic taken;
  // no second pulse until the request has dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      taken <= 1'b0;
      nmi_accept <= 1'b0;
    end else begin
      nmi_accept <= 1'b0;
      if (!nmi_request) begin
        cnt <= 0;
        taken <= 1'b0;
      end else if (!taken && cnt == DELAY) begin
        nmi_accept <= 1'b1;
        taken <= 1'b1;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule

// [testbench/tb_nmi_irl_control_and_request_regs.sv]
// Purpose: register, nmi and pin mode checks
// Assumes: one cycle apb access, 2 flop pin sync
// Notes: status mask bit 1 enables the event
`timescale 1ns/1ps
module tb_nmi_irl_control_and_request_regs;
  import nirc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, nmi_pin, cpu_block_bit, nmi_accept;
  logic timer3_underflow_req, timer4_underflow_req, nmi_request, mask_others, standby_wake_block, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] ext_request_pin, ext_level, ext_indep, timer3_level, timer4_level;
  nirc_pmode_t power_mode;
  int fails, checks_done;
  nirc_ctrl i_nirc_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .nmi_pin, .ext_request_pin, .cpu_block_bit, .nmi_accept, .power_mode, .timer3_underflow_req,
    .timer4_underflow_req, .nmi_request, .mask_others, .standby_wake_block, .ext_level, .ext_indep,
    .timer3_level, .timer4_level, .irq);
  nirc_cpu_model i_nirc_cpu_model (.pclk, .presetn, .nmi_request, .nmi_accept);
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task print_verdict;
    if (fails == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("MISMATCH %s exp %h got %h", n, e, g);
      fails++;
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    if (pready !== 1'b1) begin
      fails++;
      print_verdict();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdc(input string n, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask
  task idle(input int k);
    repeat (k) @(negedge pclk);
  endtask
  // bounded wait for the nmi request level
  task wreq(input logic v);
    int n;
    n = 0;
    while (nmi_request !== v && n < 20) begin
      @(negedge pclk);
      n++;
    end
    chk("nmi_request", {31'h0, v}, {31'h0, nmi_request});
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata, cpu_block_bit, presetn} = '0;
    {timer3_underflow_req, timer4_underflow_req, fails, checks_done} = '0;
    nmi_pin = 1'b1;
    ext_request_pin = 4'hF;
    power_mode = NIRC_RUN;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdc("ctrl", NIRC_OFS_CTRL, 32'h0000_8000);
    rdc("prio", NIRC_OFS_PRIO, 32'h0);
    rdc("req", NIRC_OFS_REQ, 32'h0);
    apb(1'b1, NIRC_OFS_CTRL, 32'hFFFF_FFFF);
    rdc("ctrl", NIRC_OFS_CTRL, 32'h0000_C380);
    apb(1'b1, NIRC_OFS_PRIO, 32'hFFFF_FFFF);
    rdc("prio", NIRC_OFS_PRIO, 32'h0000_FF00);
    apb(1'b1, NIRC_OFS_PRIO, 32'h0000_A500);
    rdc("prio", NIRC_OFS_PRIO, 32'h0000_A500);
    chk("t4 level", 32'hA, {28'h0, timer4_level});
    chk("t3 level", 32'h5, {28'h0, timer3_level});
    rdc("unmapped", 12'h0FC, 32'h0);
    chk("slverr", 32'h0, {31'h0, pslverr});
    timer3_underflow_req <= 1'b1;
    rdc("req", NIRC_OFS_REQ, 32'h0000_0100);
    timer4_underflow_req <= 1'b1;
    apb(1'b1, NIRC_OFS_REQ, 32'hFFFF_FFFF);
    rdc("req", NIRC_OFS_REQ, 32'h0000_0300);
    idle(2);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, NIRC_OFS_IRQ_MASK, 32'h6);
    idle(2);
    chk("irq", 32'h1, {31'h0, irq});
    rdc("stat", NIRC_OFS_IRQ_STAT, 32'h6);
    timer3_underflow_req <= 1'b0;
    timer4_underflow_req <= 1'b0;
    rdc("stat", NIRC_OFS_IRQ_STAT, 32'h0);
    rdc("req", NIRC_OFS_REQ, 32'h0);
    chk("irq clr", 32'h0, {31'h0, irq});
    ext_request_pin <= 4'hA;
    apb(1'b1, NIRC_OFS_CTRL, 32'h0);
    idle(4);
    chk("ext enc", 32'h5_0, {24'h0, ext_level, ext_indep});
    apb(1'b1, NIRC_OFS_CTRL, 32'h80);
    idle(4);
    chk("ext ind", 32'h0_5, {24'h0, ext_level, ext_indep});
    apb(1'b1, NIRC_OFS_CTRL, 32'h0);
    nmi_pin <= 1'b0;
    wreq(1'b1);
    chk("mask off", 32'h0, {31'h0, mask_others});
    wreq(1'b0);
    rdc("ctrl low", NIRC_OFS_CTRL, 32'h0);
    rdc("stat nmi", NIRC_OFS_IRQ_STAT, 32'h1);
    nmi_pin <= 1'b1;
    idle(8);
    chk("no rise", 32'h0, {31'h0, nmi_request});
    apb(1'b1, NIRC_OFS_CTRL, 32'h300);
    cpu_block_bit <= 1'b1;
    nmi_pin <= 1'b0;
    idle(8);
    chk("no fall", 32'h0, {31'h0, nmi_request});
    @(posedge pclk);
    nmi_pin <= 1'b1;
    wreq(1'b1);
    wreq(1'b0);
    rdc("ctrl nmi_block_mode", NIRC_OFS_CTRL, 32'h0000_8100);
    nmi_pin <= 1'b0;
    idle(6);
    @(posedge pclk);
    nmi_pin <= 1'b1;
    idle(10);
    chk("held", 32'h0, {31'h0, nmi_request});
    @(posedge pclk);
    cpu_block_bit <= 1'b0;
    wreq(1'b1);
    wreq(1'b0);
    apb(1'b1, NIRC_OFS_CTRL, 32'h4000);
    power_mode <= NIRC_SLEEP;
    nmi_pin <= 1'b0;
    wreq(1'b1);
    chk("mask on", 32'h1, {31'h0, mask_others});
    wreq(1'b0);
    @(posedge pclk);
    power_mode <= NIRC_STANDBY;
    idle(3);
    chk("no wake", 32'h1, {31'h0, standby_wake_block});
    @(posedge pclk);
    nmi_pin <= 1'b1;
    idle(6);
    chk("wake", 32'h0, {31'h0, standby_wake_block});
    chk("unmask", 32'h0, {31'h0, mask_others});
    print_verdict();
  end
  initial begin
    repeat (100000) @(posedge pclk);
    fails++;
    print_verdict();
  end
endmodule

// [verilog/nirc_ctrl.sv]
// Purpose: nmi detection, ext pin mode, source levels and raw request flags
// Assumes: apb3 slave, one cycle access, pready always high
// Notes: standby does not reset any register
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
module nirc_ctrl
  import nirc_pkg::*;
(
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins and cpu side
  input wire logic nmi_pin,
  input wire logic [3:0] ext_request_pin,
  input wire logic cpu_block_bit,
  input wire logic nmi_accept,
  input wire nirc_pmode_t power_mode,
  // peripheral requests
  input wire logic timer3_underflow_req,
  input wire logic timer4_underflow_req,
  // outputs
  output logic nmi_request,
  output logic mask_others,
  output logic standby_wake_block,
  output logic [3:0] ext_level,
  output logic [3:0] ext_indep,
  output logic [3:0] timer3_level,
  output logic [3:0] timer4_level,
  output logic irq
);
  nirc_ctrl_t ctrl, next_ctrl;
  nirc_levels_t lvl, next_lvl;
  logic [31:0] req, next_req;
  logic [NIRC_EV_W-1:0] stat, next_stat, msk, next_msk;
  logic nmi_s, nmi_d, next_nmi_d;
  logic nmi_pend, next_nmi_pend;
  logic [3:0] ext_s;
  logic [31:0] next_prdata;
  logic next_nmi_request, next_mask_others, next_wake_block, next_irq;
  logic [3:0] next_ext_level, next_ext_indep;
  logic wr, rd, edge_hit;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction

  nirc_sync #(.WIDTH(1), .INIT(1'b1)) u_nmi_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(nmi_pin),
    .q(nmi_s)
  );
  nirc_sync #(.WIDTH(4), .INIT(4'hF)) u_ext_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(ext_request_pin),
    .q(ext_s)
  );

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  // edge on the synchronised level only
  assign edge_hit = ctrl.edge_sel ? (nmi_s && !nmi_d) : (!nmi_s && nmi_d);

  always_comb begin
    next_ctrl = ctrl;
    next_lvl = lvl;
    next_msk = msk;
    next_nmi_d = nmi_s;
    next_nmi_pend = nmi_pend;
    next_stat = stat;
    next_prdata = prdata;
    if (wr && hit(paddr, NIRC_OFS_CTRL)) begin
      // pin level and reserved bits are not writable
      next_ctrl.mask_all = pwdata[NIRC_BIT_MASK_ALL];
      next_ctrl.block_mode = pwdata[NIRC_BIT_BLOCK_MODE];
      next_ctrl.edge_sel = pwdata[NIRC_BIT_EDGE_SEL];
      next_ctrl.pin_mode = pwdata[NIRC_BIT_PIN_MODE];
    end
    if (wr && hit(paddr, NIRC_OFS_PRIO)) begin
      next_lvl.t4 = pwdata[NIRC_LVL_T4_LSB +: 4];
      next_lvl.t3 = pwdata[NIRC_LVL_T3_LSB +: 4];
    end
    if (wr && hit(paddr, NIRC_OFS_IRQ_MASK)) begin
      next_msk = pwdata[NIRC_EV_W-1:0];
    end
    if (nmi_accept) begin
      next_ctrl.block_mode = 1'b0;
      next_nmi_pend = 1'b0;
    end
    if (edge_hit) begin
      next_nmi_pend = 1'b1;
    end
    // read of status clears it; new events win
    if (rd && hit(paddr, NIRC_OFS_IRQ_STAT)) begin
      next_stat = '0;
    end
    next_stat[NIRC_EV_NMI] = next_stat[NIRC_EV_NMI] | edge_hit;
    next_stat[NIRC_EV_T3] = next_stat[NIRC_EV_T3] | (timer3_underflow_req & ~req[NIRC_REQ_T3]);
    next_stat[NIRC_EV_T4] = next_stat[NIRC_EV_T4] | (timer4_underflow_req & ~req[NIRC_REQ_T4]);
    if (rd) begin
      next_prdata = 32'h0000_0000;
      if (hit(paddr, NIRC_OFS_CTRL)) begin
        next_prdata[NIRC_BIT_PIN_LEVEL] = nmi_s;
        next_prdata[NIRC_BIT_MASK_ALL] = ctrl.mask_all;
        next_prdata[NIRC_BIT_BLOCK_MODE] = ctrl.block_mode;
        next_prdata[NIRC_BIT_EDGE_SEL] = ctrl.edge_sel;
        next_prdata[NIRC_BIT_PIN_MODE] = ctrl.pin_mode;
      end else if (hit(paddr, NIRC_OFS_PRIO)) begin
        next_prdata[NIRC_LVL_T4_LSB +: 4] = lvl.t4;
        next_prdata[NIRC_LVL_T3_LSB +: 4] = lvl.t3;
      end else if (hit(paddr, NIRC_OFS_REQ)) begin
        next_prdata = req;
      end else if (hit(paddr, NIRC_OFS_IRQ_STAT)) begin
        next_prdata[NIRC_EV_W-1:0] = stat;
      end else if (hit(paddr, NIRC_OFS_IRQ_MASK)) begin
        next_prdata[NIRC_EV_W-1:0] = msk;
      end
    end
  end

  always_comb begin
    next_req = NIRC_REQ_RST;
    next_req[NIRC_REQ_T3] = timer3_underflow_req;
    next_req[NIRC_REQ_T4] = timer4_underflow_req;
    // block bit holds nmi pending unless block mode set
    next_nmi_request = nmi_pend && !nmi_accept && (!cpu_block_bit || ctrl.block_mode);
    // nmi itself stays acceptable outside standby
    next_mask_others = ctrl.mask_all && !nmi_s;
    if (power_mode == NIRC_STANDBY && ctrl.mask_all && !nmi_s) begin
      next_nmi_request = 1'b0;
    end
    next_wake_block = (power_mode == NIRC_STANDBY) && ctrl.mask_all && !nmi_s;
    if (!ctrl.pin_mode) begin
      next_ext_level = ~ext_s;
      next_ext_indep = 4'h0;
    end else begin
      next_ext_level = 4'h0;
      next_ext_indep = ~ext_s;
    end
    next_irq = |(stat & msk);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= NIRC_CTRL_RST[$bits(nirc_ctrl_t)-1:0];
      lvl <= NIRC_PRIO_RST[7:0];
      req <= NIRC_REQ_RST;
      stat <= NIRC_EV_RST;
      msk <= NIRC_EV_RST;
      nmi_d <= 1'b1;
      nmi_pend <= 1'b0;
      prdata <= 32'h0000_0000;
      nmi_request <= 1'b0;
      mask_others <= 1'b0;
      standby_wake_block <= 1'b0;
      ext_level <= 4'h0;
      ext_indep <= 4'h0;
      irq <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      lvl <= next_lvl;
      req <= next_req;
      stat <= next_stat;
      msk <= next_msk;
      nmi_d <= next_nmi_d;
      nmi_pend <= next_nmi_pend;
      prdata <= next_prdata;
      nmi_request <= next_nmi_request;
      mask_others <= next_mask_others;
      standby_wake_block <= next_wake_block;
      ext_level <= next_ext_level;
      ext_indep <= next_ext_indep;
      irq <= next_irq;
    end
  end

  // level 0 masks a source downstream, 15 is highest
  assign timer3_level = lvl.t3;
  assign timer4_level = lvl.t4;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  chk_block_clear: assert property (@(posedge pclk) disable iff (!presetn)
    nmi_accept |=> !ctrl.block_mode) else $error("block mode not cleared on accept");
  chk_edge_pend: assert property (@(posedge pclk) disable iff (!presetn)
    edge_hit |=> nmi_pend) else $error("nmi edge not latched");
  chk_held_blocked: assert property (@(posedge pclk) disable iff (!presetn)
    (cpu_block_bit && !ctrl.block_mode) |=> !nmi_request) else $error("nmi issued while blocked");
  chk_mask_low: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl.mask_all && !nmi_s) |=> mask_others) else $error("mask not applied while pin low");
  chk_mask_off: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl.mask_all |=> !mask_others) else $error("mask without mask bit");
  chk_standby_wake: assert property (@(posedge pclk) disable iff (!presetn)
    (power_mode == NIRC_STANDBY && ctrl.mask_all && !nmi_s) |=> (standby_wake_block && !nmi_request))
    else $error("standby not held");
  chk_level_read: assert property (@(posedge pclk) disable iff (!presetn)
    (rd && hit(paddr, NIRC_OFS_CTRL)) |=> prdata[NIRC_BIT_PIN_LEVEL] == $past(nmi_s))
    else $error("pin level read wrong");
  chk_prio_hi: assert property (@(posedge pclk) disable iff (!presetn)
    (rd && hit(paddr, NIRC_OFS_PRIO)) |=> prdata[31:16] == 16'h0000) else $error("prio upper bits set");
  chk_req_t4: assert property (@(posedge pclk) disable iff (!presetn)
    timer4_underflow_req |=> req[NIRC_REQ_T4]) else $error("timer4 request not flagged");
  chk_pin_mode: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl.pin_mode |=> ext_level == 4'h0) else $error("encoded output in independent mode");
  cov_nmi_fall: cover property (@(posedge pclk) disable iff (!presetn) edge_hit && !ctrl.edge_sel);
  cov_nmi_rise: cover property (@(posedge pclk) disable iff (!presetn) edge_hit && ctrl.edge_sel);
  cov_accept: cover property (@(posedge pclk) disable iff (!presetn) nmi_request ##1 nmi_accept);
  cov_irq: cover property (@(posedge pclk) disable iff (!presetn) irq);
  cov_standby: cover property (@(posedge pclk) disable iff (!presetn) standby_wake_block);

  // register writes and holds
  chk_ctrl_wmask: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit(paddr, NIRC_OFS_CTRL)) |=> ctrl.mask_all == $past(pwdata[NIRC_BIT_MASK_ALL]))
    else $error("mask bit write lost");
  chk_ctrl_wedge: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit(paddr, NIRC_OFS_CTRL)) |=> ctrl.edge_sel == $past(pwdata[NIRC_BIT_EDGE_SEL]))
    else $error("edge select write lost");
  chk_ctrl_wpin: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit(paddr, NIRC_OFS_CTRL)) |=> ctrl.pin_mode == $past(pwdata[NIRC_BIT_PIN_MODE]))
    else $error("pin mode write lost");
  chk_ctrl_wblock: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit(paddr, NIRC_OFS_CTRL) && !nmi_accept) |=> ctrl.block_mode == $past(pwdata[NIRC_BIT_BLOCK_MODE]))
    else $error("block mode write lost");
  chk_ctrl_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (!(wr && hit(paddr, NIRC_OFS_CTRL)) && !nmi_accept) |=> $stable(ctrl))
    else $error("control changed without write");
  chk_lvl_t4_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit(paddr, NIRC_OFS_PRIO)) |=> lvl.t4 == $past(pwdata[NIRC_LVL_T4_LSB +: 4]))
    else $error("timer4 level write lost");
  chk_lvl_t3_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit(paddr, NIRC_OFS_PRIO)) |=> lvl.t3 == $past(pwdata[NIRC_LVL_T3_LSB +: 4]))
    else $error("timer3 level write lost");
  chk_lvl_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr && hit(paddr, NIRC_OFS_PRIO)) |=> $stable(lvl))
    else $error("levels changed without write");
  chk_msk_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit(paddr, NIRC_OFS_IRQ_MASK)) |=> msk == $past(pwdata[NIRC_EV_W-1:0]))
    else $error("mask write lost");
  chk_msk_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr && hit(paddr, NIRC_OFS_IRQ_MASK)) |=> $stable(msk))
    else $error("mask changed without write");
  // raw request flags
  chk_req_t3: assert property (@(posedge pclk) disable iff (!presetn)
    timer3_underflow_req |=> req[NIRC_REQ_T3])
    else $error("timer3 request not flagged");
  chk_req_t3_drop: assert property (@(posedge pclk) disable iff (!presetn)
    !timer3_underflow_req |=> !req[NIRC_REQ_T3])
    else $error("timer3 request stuck");
  chk_req_t4_drop: assert property (@(posedge pclk) disable iff (!presetn)
    !timer4_underflow_req |=> !req[NIRC_REQ_T4])
    else $error("timer4 request stuck");
  chk_req_resv: assert property (@(posedge pclk) disable iff (!presetn)
    req[31:10] == 22'h0 && req[7:0] == 8'h00)
    else $error("reserved request bit set");
  // read data
  chk_prio_read: assert property (@(posedge pclk) disable iff (!presetn)
    (rd && hit(paddr, NIRC_OFS_PRIO)) |=> prdata[15:8] == {$past(lvl.t4), $past(lvl.t3)})
    else $error("level read wrong");
  chk_prio_resv: assert property (@(posedge pclk) disable iff (!presetn)
    (rd && hit(paddr, NIRC_OFS_PRIO)) |=> prdata[7:0] == 8'h00)
    else $error("prio low bits set");
  chk_ctrl_resv: assert property (@(posedge pclk) disable iff (!presetn)
    (rd && hit(paddr, NIRC_OFS_CTRL)) |=> prdata[31:16] == 16'h0000 && prdata[13:10] == 4'h0 && prdata[6:0] == 7'h00)
    else $error("reserved control bit set");
  chk_ctrl_read: assert property (@(posedge pclk) disable iff (!presetn)
    (rd && hit(paddr, NIRC_OFS_CTRL)) |=> prdata[14] == $past(ctrl.mask_all)
      && prdata[9:7] == {$past(ctrl.block_mode), $past(ctrl.edge_sel), $past(ctrl.pin_mode)})
    else $error("control read wrong");
  chk_req_read: assert property (@(posedge pclk) disable iff (!presetn)
    (rd && hit(paddr, NIRC_OFS_REQ)) |=> prdata == $past(req))
    else $error("request read wrong");
  chk_stat_read: assert property (@(posedge pclk) disable iff (!presetn)
    (rd && hit(paddr, NIRC_OFS_IRQ_STAT)) |=> prdata[NIRC_EV_W-1:0] == $past(stat))
    else $error("status read wrong");
  chk_msk_read: assert property (@(posedge pclk) disable iff (!presetn)
    (rd && hit(paddr, NIRC_OFS_IRQ_MASK)) |=> prdata[NIRC_EV_W-1:0] == $past(msk))
    else $error("mask read wrong");
  chk_rdata_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !rd |=> $stable(prdata))
    else $error("read data moved without read");
  chk_unmapped_read: assert property (@(posedge pclk) disable iff (!presetn)
    (rd && !hit(paddr, NIRC_OFS_CTRL) && !hit(paddr, NIRC_OFS_PRIO) && !hit(paddr, NIRC_OFS_REQ)
      && !hit(paddr, NIRC_OFS_IRQ_STAT) && !hit(paddr, NIRC_OFS_IRQ_MASK)) |=> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    pready && !pslverr)
    else $error("bus answer wrong");
  // status and interrupt
  chk_stat_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (rd && hit(paddr, NIRC_OFS_IRQ_STAT) && !edge_hit) |=> !stat[NIRC_EV_NMI])
    else $error("status not cleared by read");
  chk_stat_nmi: assert property (@(posedge pclk) disable iff (!presetn)
    edge_hit |=> stat[NIRC_EV_NMI])
    else $error("nmi edge not in status");
  chk_stat_t3: assert property (@(posedge pclk) disable iff (!presetn)
    (timer3_underflow_req && !req[NIRC_REQ_T3]) |=> stat[NIRC_EV_T3])
    else $error("timer3 event lost");
  chk_stat_t4: assert property (@(posedge pclk) disable iff (!presetn)
    (timer4_underflow_req && !req[NIRC_REQ_T4]) |=> stat[NIRC_EV_T4])
    else $error("timer4 event lost");
  chk_stat_keep: assert property (@(posedge pclk) disable iff (!presetn)
    (stat[NIRC_EV_NMI] && !(rd && hit(paddr, NIRC_OFS_IRQ_STAT))) |=> stat[NIRC_EV_NMI])
    else $error("status bit lost");
  chk_irq_on: assert property (@(posedge pclk) disable iff (!presetn)
    ((stat & msk) != 3'h0) |=> irq)
    else $error("irq missing");
  chk_irq_off: assert property (@(posedge pclk) disable iff (!presetn)
    ((stat & msk) == 3'h0) |=> !irq)
    else $error("irq without unmasked status");
  // nmi request path
  chk_accept_drop: assert property (@(posedge pclk) disable iff (!presetn)
    nmi_accept |=> !nmi_request)
    else $error("request kept after accept");
  chk_accept_pend: assert property (@(posedge pclk) disable iff (!presetn)
    (nmi_accept && !edge_hit) |=> !nmi_pend)
    else $error("pending kept after accept");
  chk_issue_free: assert property (@(posedge pclk) disable iff (!presetn)
    (nmi_pend && !nmi_accept && !cpu_block_bit && power_mode != NIRC_STANDBY) |=> nmi_request)
    else $error("free nmi not issued");
  chk_issue_mode: assert property (@(posedge pclk) disable iff (!presetn)
    (nmi_pend && !nmi_accept && ctrl.block_mode && power_mode != NIRC_STANDBY) |=> nmi_request)
    else $error("nmi not issued in block mode");
  chk_sleep_accept: assert property (@(posedge pclk) disable iff (!presetn)
    (power_mode == NIRC_SLEEP && ctrl.mask_all && nmi_pend && !nmi_accept && !cpu_block_bit) |=> nmi_request)
    else $error("nmi refused in sleep");
  chk_no_pend: assert property (@(posedge pclk) disable iff (!presetn)
    !nmi_pend |=> !nmi_request)
    else $error("request without pending");
  chk_pend_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (nmi_pend && !nmi_accept) |=> nmi_pend)
    else $error("pending lost");
  chk_pend_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (!nmi_pend && !edge_hit) |=> !nmi_pend)
    else $error("pending without edge");
  chk_single_edge: assert property (@(posedge pclk) disable iff (!presetn)
    edge_hit ##1 $stable(ctrl.edge_sel) |-> !edge_hit)
    else $error("one edge seen twice");
  chk_wake_off: assert property (@(posedge pclk) disable iff (!presetn)
    (power_mode != NIRC_STANDBY) |=> !standby_wake_block)
    else $error("wake blocked outside standby");
  chk_wake_pin: assert property (@(posedge pclk) disable iff (!presetn)
    nmi_s |=> !standby_wake_block)
    else $error("wake blocked with pin high");
  chk_mask_high: assert property (@(posedge pclk) disable iff (!presetn)
    nmi_s |=> !mask_others)
    else $error("mask with pin high");
  // external pin mode
  chk_enc_out: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl.pin_mode |=> ext_level == ~$past(ext_s) && ext_indep == 4'h0)
    else $error("encoded pins wrong");
  chk_ind_out: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl.pin_mode |=> ext_indep == ~$past(ext_s))
    else $error("independent pins wrong");
endmodule

// [verilog/nirc_pkg.sv]
// Purpose: shared constants and types for the nmi / ext-request control block
// Assumes: apb slave, 32-bit words, offsets chosen locally
// Notes: reserved bits read as zero
// How it works
// - control register is 16 bits, reset by reset only, kept through standby
// - bit 15 shows the live synchronised nmi pin level, writes ignored
// - low-level mask set masks other interrupts while nmi pin is low
// - nmi still accepted under low-level mask in normal and sleep
// - in standby with low-level mask, everything masked, no wake while pin low
// - block mode 0 holds nmi pending under cpu block bit, 1 detects at once
// - block mode bit cleared by hardware when nmi is accepted
// - edge select 0 detects falling nmi edge, 1 rising edge
// - ext pin mode 0 level-encoded request, 1 four independent level requests
// - reserved control bits read 0, software writes 0
// - priority register 32 bits, reset zero, bits 15:8 writable only
// - each 4-bit level 0..15, 15 highest, 0 masks the source
// - bits 15:12 timer channel 4 level, bits 11:8 timer channel 3 level
// - raw request register read-only, unaffected by level or individual mask
// - request bit is 1 while request outstanding, 0 after reset
// - request bit 9 timer4 underflow, bit 8 timer3 underflow
package nirc_pkg;
  localparam logic [11:0] NIRC_OFS_CTRL = 12'h000;
  localparam logic [11:0] NIRC_OFS_PRIO = 12'h004;
  localparam logic [11:0] NIRC_OFS_REQ = 12'h008;
  localparam logic [11:0] NIRC_OFS_IRQ_STAT = 12'h00C;
  localparam logic [11:0] NIRC_OFS_IRQ_MASK = 12'h010;
  localparam int NIRC_BIT_PIN_LEVEL = 15;
  localparam int NIRC_BIT_MASK_ALL = 14;
  localparam int NIRC_BIT_BLOCK_MODE = 9;
  localparam int NIRC_BIT_EDGE_SEL = 8;
  localparam int NIRC_BIT_PIN_MODE = 7;
  localparam logic [15:0] NIRC_CTRL_RST = 16'h0000;
  localparam logic [15:0] NIRC_CTRL_WMASK = 16'h4380;
  localparam logic [31:0] NIRC_PRIO_RST = 32'h0000_0000;
  localparam logic [31:0] NIRC_PRIO_WMASK = 32'h0000_FF00;
  localparam int NIRC_LVL_T4_LSB = 12;
  localparam int NIRC_LVL_T3_LSB = 8;
  localparam int NIRC_REQ_T4 = 9;
  localparam int NIRC_REQ_T3 = 8;
  localparam logic [31:0] NIRC_REQ_RST = 32'h0000_0000;
  // status / mask bit positions
  localparam int NIRC_EV_NMI = 0;
  localparam int NIRC_EV_T3 = 1;
  localparam int NIRC_EV_T4 = 2;
  localparam int NIRC_EV_W = 3;
  localparam logic [NIRC_EV_W-1:0] NIRC_EV_RST = 3'h0;
  typedef struct packed {
    logic mask_all;
    logic block_mode;
    logic edge_sel;
    logic pin_mode;
  } nirc_ctrl_t;
  typedef struct packed {
    logic [3:0] t4;
    logic [3:0] t3;
  } nirc_levels_t;
  typedef enum logic [1:0] {NIRC_RUN, NIRC_SLEEP, NIRC_STANDBY} nirc_pmode_t;
endpackage

// [verilog/nirc_sync.sv]
// Purpose: two-flop synchroniser for asynchronous pins
// Assumes: pin levels change slowly compared with pclk
// Notes: first stage is read by the second only
`timescale 1ns/1ps
module nirc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] stage1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= INIT;
      q <= INIT;
    end else begin
      stage1 <= d;
      q <= stage1;
    end
  end
endmodule
